// file: hdl/ezs_pkg.sv
// Shared constants and types for the eight-zero substitution transcoder
package ezs_pkg;
  // ----------------------------------------
  // Widths and counts
  // ----------------------------------------
  localparam int unsigned        ZRUN_W        = 3;     // Zero-run counter width
  localparam logic [2:0]         ZRUN_LAST     = 3'h7;  // Count seen before the eighth zero
  localparam int unsigned        ENC_DLY_LEN   = 5;     // Encoder input delay stages
  localparam int unsigned        DEC_BUF_LEN   = 8;     // Decoder output buffer stages
  localparam int unsigned        REG_AW        = 4;     // Register address width
  localparam int unsigned        REG_DW        = 8;     // Register data width
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic               ENC_POL_RST   = 1'b0;  // Previous mark taken as negative
  localparam logic               DEC_POL_RST   = 1'b0;  // Same convention on receive
  localparam logic [REG_DW-1:0]  MASK_RST      = 8'h00; // All interrupts masked
  // ----------------------------------------
  // Register map and status fields
  // ----------------------------------------
  localparam logic [REG_AW-1:0]  OFS_STATUS    = 4'h0;  // Sticky events, write one to clear
  localparam logic [REG_AW-1:0]  OFS_MASK      = 4'h4;  // Interrupt mask
  localparam logic [REG_AW-1:0]  OFS_LIVE      = 4'h8;  // Live state, read only
  localparam int unsigned        ST_SUBST      = 0;     // Substitution recognised
  localparam int unsigned        ST_VIOL       = 1;     // Bipolar violation
  localparam int unsigned        ST_RAIL       = 2;     // Both rails high
  localparam int unsigned        ST_W          = 3;     // Number of event bits
  // ----------------------------------------
  // State machines
  // ----------------------------------------
  typedef enum logic [2:0] {
    ES_IDLE = 3'h0, ES_P4 = 3'h3, ES_P5 = 3'h4, ES_P6 = 3'h5, ES_P7 = 3'h6, ES_P8 = 3'h7
  } ezs_seq_t;
  typedef enum logic [3:0] {
    DS_Z0 = 4'h0, DS_Z1 = 4'h1, DS_Z2 = 4'h2, DS_Z3 = 4'h3,
    DS_AP = 4'h4, DS_APM = 4'h5, DS_APM0 = 4'h6, DS_APM0M = 4'h7,
    DS_BM = 4'h8, DS_BMP = 4'h9, DS_BMP0 = 4'ha, DS_BMP0P = 4'hb
  } ezs_dec_t;
endpackage

// file: hdl/ezs_transcoder.sv
// Eight-zero substitution bipolar line transcoder, encoder and decoder
// Contract
// (R1) Three-bit counter finds runs of eight zeros on the NRZ input.
// (R2) Five-stage delay aligns input bits with the zero-run count.
// (R3) Three-bit sequence machine walks substitution positions for the encoder.
// (R4) Encoder drives positive and negative rails; neither means zero level.
// (R5) Decoder turns 000+-0-+ or 000-+0+- back into eight zeros.
// (R6) Outside patterns, any mark decodes to one, zero level to zero.
// (R7) Decoder pattern machine uses four state bits.
// (R8) Decoded bits wait in eight stages, all cleared on a recognised pattern.
// (R9) Pattern-detected output asserts when a substitution is recognised.
// (R10) Same-polarity successive marks flag a violation unless inside a pattern.
// (R11) Error asserts when both input rails are high together.
// (R12) Encoder alternates mark polarity for ones outside substitutions.
// (R13) Eight zeros become 000+-0-+ after positive, 000-+0+- after negative.
// (R14) Substitutions carry violations at positions four and seven.
// (R15) Master clear empties counters, buffers, machines, flags; polarity defined.
// (R16) Everything runs on one clock edge, one symbol and bit per period.
`timescale 1ns/1ps
`default_nettype none
module ezs_transcoder
  import ezs_pkg::*;
(
  input  wire logic              clk_sys,          // System clock, 25 MHz
  input  wire logic              rst_n,            // Async reset, active low
  input  wire logic              global_clear,     // Master clear pin
  input  wire logic              nrz_serial_in,    // NRZ data to encode
  input  wire logic              line_in_pos_rail, // Received positive rail
  input  wire logic              line_in_neg_rail, // Received negative rail
  output logic                   line_out_pos_rail,// Encoded positive rail
  output logic                   line_out_neg_rail,// Encoded negative rail
  output logic                   nrz_serial_out,   // Decoded NRZ data
  output logic                   polarity_violation_flag, // Violation pulse
  output logic                   substitution_seen,// Pattern pulse
  output logic                   rail_error,       // Both rails high pulse
  input  wire logic [REG_AW-1:0] reg_addr,         // Register address
  input  wire logic [REG_DW-1:0] reg_wdata,        // Register write data
  input  wire logic              reg_wr,           // Write strobe
  input  wire logic              reg_rd,           // Read strobe
  output logic      [REG_DW-1:0] reg_rdata,        // Read data, cycle after strobe
  output logic                   irq               // Level interrupt
);
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [3:0] sync_a;
  logic [3:0] sync_b;
  logic       clr;
  logic       din;
  logic       rx_p;
  logic       rx_n;
  // Pins are asynchronous; only the second stage feeds logic
  always_ff @(posedge clk_sys or negedge rst_n) begin // R16
    if (!rst_n) begin
      sync_a <= 4'h0;
      sync_b <= 4'h0;
    end else begin
      sync_a <= {global_clear, nrz_serial_in, line_in_pos_rail, line_in_neg_rail};
      sync_b <= sync_a;
    end
  end
  assign clr  = sync_b[3];
  assign din  = sync_b[2];
  assign rx_p = sync_b[1];
  assign rx_n = sync_b[0];

  // ----------------------------------------
  // Encoder
  // ----------------------------------------
  logic [ZRUN_W-1:0]      zrun, next_zrun;
  logic [ENC_DLY_LEN-1:0] dly, next_dly;
  ezs_seq_t               seq, next_seq;
  logic                   enc_pol, next_enc_pol;
  logic                   enc_pos, next_enc_pos;
  logic                   enc_neg, next_enc_neg;
  logic                   zrun_hit;

  // Eighth zero seen now: its fourth zero leaves the delay next cycle
  assign zrun_hit = !din && (zrun == ZRUN_LAST); // R1

  always_comb begin
    next_zrun    = din ? '0 : zrun + 3'h1; // R1
    next_dly     = {dly[ENC_DLY_LEN-2:0], din}; // R2
    next_seq     = seq;
    next_enc_pol = enc_pol;
    next_enc_pos = 1'b0;
    next_enc_neg = 1'b0;
    // Positions walk 4..8 after a hit; a new hit needs eight fresh zeros
    unique case (seq) // R3
      ES_IDLE: next_seq = zrun_hit ? ES_P4 : ES_IDLE;
      ES_P4:   next_seq = ES_P5;
      ES_P5:   next_seq = ES_P6;
      ES_P6:   next_seq = ES_P7;
      ES_P7:   next_seq = ES_P8;
      ES_P8:   next_seq = ES_IDLE;
    endcase
    // Pattern marks relative to the preceding polarity p: p, ~p, 0, ~p, p
    unique case (seq) // R13
      ES_P4, ES_P8: begin // R14
        next_enc_pos = enc_pol;
        next_enc_neg = !enc_pol;
      end
      ES_P5, ES_P7: begin // R14
        next_enc_pos = !enc_pol;
        next_enc_neg = enc_pol;
      end
      ES_P6: ;
      ES_IDLE: begin
        if (dly[ENC_DLY_LEN-1]) begin // R12
          next_enc_pol = !enc_pol;
          next_enc_pos = !enc_pol;
          next_enc_neg = enc_pol;
        end
      end
    endcase
    if (clr) begin // R15
      next_zrun    = '0;
      next_dly     = '0;
      next_seq     = ES_IDLE;
      next_enc_pol = ENC_POL_RST;
      next_enc_pos = 1'b0;
      next_enc_neg = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin // R16
    if (!rst_n) begin
      zrun    <= '0;
      dly     <= '0;
      seq     <= ES_IDLE;
      enc_pol <= ENC_POL_RST;
      enc_pos <= 1'b0;
      enc_neg <= 1'b0;
    end else begin
      zrun    <= next_zrun;
      dly     <= next_dly;
      seq     <= next_seq;
      enc_pol <= next_enc_pol;
      enc_pos <= next_enc_pos;
      enc_neg <= next_enc_neg;
    end
  end
  assign line_out_pos_rail = enc_pos; // R4
  assign line_out_neg_rail = enc_neg; // R4

  // ----------------------------------------
  // Decoder
  // ----------------------------------------
  ezs_dec_t               dst, next_dst;
  logic [DEC_BUF_LEN-1:0] dbuf, next_dbuf;
  logic [DEC_BUF_LEN-1:0] vbuf, next_vbuf;
  logic                   dec_pol, next_dec_pol;
  logic                   sub_q, next_sub_q;
  logic                   vio_q, next_vio_q;
  logic                   rerr_q, next_rerr_q;
  logic                   m_pos, m_neg, m_zero, detect, same_pol;

  // A both-high symbol is treated as a zero level and only raises the error
  assign m_pos    = rx_p && !rx_n;
  assign m_neg    = rx_n && !rx_p;
  assign m_zero   = !(m_pos || m_neg);
  assign same_pol = (m_pos && dec_pol) || (m_neg && !dec_pol); // R10

  always_comb begin
    next_dst = DS_Z0;
    detect   = 1'b0;
    // Three zeros then V B 0 V B in either polarity
    unique case (dst) // R7
      DS_Z0, DS_Z1, DS_Z2: next_dst = m_zero ? ezs_dec_t'(dst + 4'h1) : DS_Z0;
      DS_Z3:    next_dst = m_zero ? DS_Z3 : (m_pos ? DS_AP : DS_BM);
      DS_AP:    next_dst = m_neg ? DS_APM : (m_zero ? DS_Z1 : DS_Z0);
      DS_APM:   next_dst = m_zero ? DS_APM0 : DS_Z0;
      DS_APM0:  next_dst = m_neg ? DS_APM0M : (m_zero ? DS_Z2 : DS_Z0);
      DS_APM0M: begin
        detect   = m_pos; // R5
        next_dst = m_zero ? DS_Z1 : DS_Z0;
      end
      DS_BM:    next_dst = m_pos ? DS_BMP : (m_zero ? DS_Z1 : DS_Z0);
      DS_BMP:   next_dst = m_zero ? DS_BMP0 : DS_Z0;
      DS_BMP0:  next_dst = m_pos ? DS_BMP0P : (m_zero ? DS_Z2 : DS_Z0);
      DS_BMP0P: begin
        detect   = m_neg; // R5
        next_dst = m_zero ? DS_Z1 : DS_Z0;
      end
      default:  next_dst = DS_Z0;
    endcase
    next_dbuf    = {dbuf[DEC_BUF_LEN-2:0], !m_zero}; // R6
    // Violations wait beside their bits so a pattern can cancel them
    next_vbuf    = {vbuf[DEC_BUF_LEN-2:0], same_pol}; // R10
    next_dec_pol = m_pos ? 1'b1 : (m_neg ? 1'b0 : dec_pol);
    if (detect) begin // R8
      next_dbuf = '0;
      next_vbuf = '0;
    end
    next_sub_q  = detect; // R9
    next_vio_q  = vbuf[DEC_BUF_LEN-1]; // R10
    next_rerr_q = rx_p && rx_n; // R11
    if (clr) begin // R15
      next_dst     = DS_Z0;
      next_dbuf    = '0;
      next_vbuf    = '0;
      next_dec_pol = DEC_POL_RST;
      next_sub_q   = 1'b0;
      next_vio_q   = 1'b0;
      next_rerr_q  = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin // R16
    if (!rst_n) begin
      dst     <= DS_Z0;
      dbuf    <= '0;
      vbuf    <= '0;
      dec_pol <= DEC_POL_RST;
      sub_q   <= 1'b0;
      vio_q   <= 1'b0;
      rerr_q  <= 1'b0;
    end else begin
      dst     <= next_dst;
      dbuf    <= next_dbuf;
      vbuf    <= next_vbuf;
      dec_pol <= next_dec_pol;
      sub_q   <= next_sub_q;
      vio_q   <= next_vio_q;
      rerr_q  <= next_rerr_q;
    end
  end
  assign nrz_serial_out          = dbuf[DEC_BUF_LEN-1];
  assign substitution_seen       = sub_q;  // R9
  assign polarity_violation_flag = vio_q;  // R10
  assign rail_error              = rerr_q; // R11

  // ----------------------------------------
  // Status, mask and interrupt
  // ----------------------------------------
  logic [ST_W-1:0]   status, next_status;
  logic [ST_W-1:0]   mask, next_mask;
  logic [ST_W-1:0]   events;
  logic [REG_DW-1:0] rdata, next_rdata;

  assign events = {rerr_q, vio_q, sub_q};

  // New events win over a write-one clear in the same cycle
  always_comb begin
    next_status = status;
    next_mask   = mask;
    next_rdata  = '0;
    if (reg_wr && reg_addr == OFS_STATUS) next_status = status & ~reg_wdata[ST_W-1:0];
    if (reg_wr && reg_addr == OFS_MASK) next_mask = reg_wdata[ST_W-1:0];
    next_status = next_status | events;
    if (clr) next_status = '0; // R15
    if (reg_rd) begin
      unique case (reg_addr)
        OFS_STATUS: next_rdata = {{(REG_DW-ST_W){1'b0}}, status};
        OFS_MASK:   next_rdata = {{(REG_DW-ST_W){1'b0}}, mask};
        OFS_LIVE:   next_rdata = {seq, dst, enc_pol};
        default:    next_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      status <= '0;
      mask   <= MASK_RST[ST_W-1:0];
      rdata  <= '0;
    end else begin
      status <= next_status;
      mask   <= next_mask;
      rdata  <= next_rdata;
    end
  end
  assign reg_rdata = rdata;
  assign irq       = |(status & mask);

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  // Helper terms; sampled-value functions take plain signals only
  logic rx_one, irq_cause;
  assign rx_one    = rx_p ^ rx_n;
  assign irq_cause = (|events) || (reg_wr && reg_addr == OFS_MASK);

  sequence s_sub_walk;
    seq == ES_P4 ##1 seq == ES_P5 ##1 seq == ES_P6 ##1 seq == ES_P7 ##1 seq == ES_P8 ##1 seq == ES_IDLE;
  endsequence
  sequence s_sub_marks(logic p);
    (enc_pos == p && enc_neg == !p) ##1 (enc_pos == !p && enc_neg == p) ##1 (!enc_pos && !enc_neg)
      ##1 (enc_pos == !p && enc_neg == p) ##1 (enc_pos == p && enc_neg == !p);
  endsequence

  a_zero_run_hit: assert property (@(posedge clk_sys) disable iff (!rst_n || clr) // R1
    (seq == ES_IDLE && zrun_hit) |=> s_sub_walk)
    else $error("zero run did not start substitution");
  a_seq_walk: assert property (@(posedge clk_sys) disable iff (!rst_n || clr) // R3
    (seq == ES_IDLE && $past(seq) == ES_P8) |-> $past(seq, 5) == ES_P4)
    else $error("sequence positions skipped");
  a_sub_pattern: assert property (@(posedge clk_sys) disable iff (!rst_n || clr) // R13
    (seq == ES_P4 && !$past(clr)) |=> s_sub_marks($past(enc_pol)))
    else $error("substitution pattern wrong");
  a_rails_apart: assert property (@(posedge clk_sys) disable iff (!rst_n) // R4
    !(line_out_pos_rail && line_out_neg_rail))
    else $error("both output rails high");
  a_mark_alt: assert property (@(posedge clk_sys) disable iff (!rst_n || clr) // R12
    (seq == ES_IDLE && dly[ENC_DLY_LEN-1]) |=> (enc_pos == !$past(enc_pol) && enc_neg == $past(enc_pol)))
    else $error("mark polarity did not alternate");
  a_delay_align: assert property (@(posedge clk_sys) disable iff (!rst_n || clr) // R2
    (seq != ES_IDLE) |-> !dly[ENC_DLY_LEN-1])
    else $error("one bit inside substituted run");
  a_sub_clear: assert property (@(posedge clk_sys) disable iff (!rst_n || clr) // R8
    detect |=> (dbuf == '0 && substitution_seen))
    else $error("pattern not replaced by zeros");
  a_mark_decode: assert property (@(posedge clk_sys) disable iff (!rst_n || clr) // R6
    !detect |=> dbuf[0] == $past(rx_one))
    else $error("symbol decoded wrongly");
  a_viol_delay: assert property (@(posedge clk_sys) disable iff (!rst_n || clr) // R10
    (same_pol && !detect) ##1 !detect [*7] |=> ##1 polarity_violation_flag)
    else $error("violation not flagged");
  a_rail_err: assert property (@(posedge clk_sys) disable iff (!rst_n || clr) // R11
    (rx_p && rx_n) |=> rail_error)
    else $error("rail error missed");
  a_irq_level: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(irq) |-> $past(irq_cause))
    else $error("interrupt rose without cause");
  a_clear_empty: assert property (@(posedge clk_sys) disable iff (!rst_n) // R15
    $past(clr) |-> (zrun == '0 && dly == '0 && seq == ES_IDLE && dst == DS_Z0 && dbuf == '0 && vbuf == '0
      && enc_pol == ENC_POL_RST && dec_pol == DEC_POL_RST && status == '0 && !substitution_seen))
    else $error("master clear left state behind");
  a_sub_only: assert property (@(posedge clk_sys) disable iff (!rst_n || clr) // R9
    !detect |=> !substitution_seen)
    else $error("pattern pulse without pattern");
  a_rail_only: assert property (@(posedge clk_sys) disable iff (!rst_n || clr) // R11
    !(rx_p && rx_n) |=> !rail_error)
    else $error("rail error without both rails high");
  a_enc_quiet: assert property (@(posedge clk_sys) disable iff (!rst_n || clr) // R4
    (seq == ES_IDLE && !dly[ENC_DLY_LEN-1]) |=> (!line_out_pos_rail && !line_out_neg_rail))
    else $error("zero bit sent as a mark");
  a_status_set: assert property (@(posedge clk_sys) disable iff (!rst_n) // R9
    (|events && !clr) |=> ((status & $past(events)) == $past(events)))
    else $error("event lost from status");
  a_rdata_idle: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !$past(reg_rd) |-> reg_rdata == '0)
    else $error("read data outside its cycle");
endmodule
`default_nettype wire

// file: bench/ezs_line_model.sv
// Line driver and receiver model between encoder rails and decoder rails
`timescale 1ns/1ps
`default_nettype none
module ezs_line_model (
  input  wire logic         tx_pos,  // Encoder positive rail
  input  wire logic         tx_neg,  // Encoder negative rail
  input  wire logic         inj_en,  // Feed receiver with injected symbol instead of line
  input  wire logic         inj_pos, // Injected positive rail
  input  wire logic         inj_neg, // Injected negative rail
  output logic signed [1:0] level,   // Three-level line voltage
  output logic              rx_pos,  // Receiver positive rail
  output logic              rx_neg   // Receiver negative rail
);
  // ----------------------------------------
  // Line level and receiver slicing
  // ----------------------------------------
  // Neither rail means zero volts; injection lets the bench break the code on purpose
  always_comb begin
    level  = tx_pos ? 2'sd1 : (tx_neg ? -2'sd1 : 2'sd0);
    rx_pos = inj_en ? inj_pos : (level == 2'sd1);
    rx_neg = inj_en ? inj_neg : (level == -2'sd1);
  end
endmodule
`default_nettype wire

// file: bench/ezs_transcoder_tb.sv
// Self-checking bench for the eight-zero substitution transcoder in loopback
`timescale 1ns/1ps
`default_nettype none
module ezs_transcoder_tb;
  import ezs_pkg::*;
  logic clk_sys, rst_n, global_clear, nrz_in, rx_pos, rx_neg, tx_pos, tx_neg, nrz_out;
  logic viol, subst, rail_err, reg_wr, reg_rd, irq, inj_en, inj_pos, inj_neg;
  logic [REG_AW-1:0] reg_addr;
  logic [REG_DW-1:0] reg_wdata, reg_rdata;
  logic signed [1:0] line_lvl;
  int mismatches = 0, compares = 0, cycles = 0, n_sub, n_viol, n_rail, exp_sub;
  logic bits[$];
  logic [1:0] sym[$];
  logic [1:0] inj_tab[8] = '{2'b00, 2'b10, 2'b00, 2'b10, 2'b00, 2'b11, 2'b00, 2'b00};
  int run_tab[4] = '{8, 15, 16, 7};

  ezs_transcoder i_ezs_transcoder (.clk_sys(clk_sys), .rst_n(rst_n), .global_clear(global_clear),
    .nrz_serial_in(nrz_in), .line_in_pos_rail(rx_pos), .line_in_neg_rail(rx_neg),
    .line_out_pos_rail(tx_pos), .line_out_neg_rail(tx_neg), .nrz_serial_out(nrz_out),
    .polarity_violation_flag(viol), .substitution_seen(subst), .rail_error(rail_err),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq));
  ezs_line_model i_ezs_line_model (.tx_pos(tx_pos), .tx_neg(tx_neg), .inj_en(inj_en), .inj_pos(inj_pos),
    .inj_neg(inj_neg), .level(line_lvl), .rx_pos(rx_pos), .rx_neg(rx_neg));

  // ----------------------------------------
  // Clock, pulse counters and hang guard
  // ----------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  // Pulses are counted in cycles, so a stretched pulse shows up as a wrong count
  always @(negedge clk_sys) begin
    if (subst === 1'b1) n_sub++;
    if (viol === 1'b1) n_viol++;
    if (rail_err === 1'b1) n_rail++;
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      conclude();
    end
  end

  // ----------------------------------------
  // Shared tasks and expectation builder
  // ----------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic reg_write(input logic [REG_AW-1:0] a, input logic [REG_DW-1:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(negedge clk_sys);
  endtask
  task automatic reg_read(input logic [REG_AW-1:0] a, output logic [REG_DW-1:0] d);
    @(posedge clk_sys);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    d = reg_rdata;
  endtask
  task automatic read_check(input logic [REG_AW-1:0] a, input logic [REG_DW-1:0] exp);
    logic [REG_DW-1:0] d;
    reg_read(a, d);
    check(d, exp);
  endtask
  // Alternate marks; every eighth zero rewrites its group as 000VB0VB, polarity kept
  function automatic void build_exp();
    logic pol;
    int z;
    pol = ENC_POL_RST;
    z = 0;
    exp_sub = 0;
    foreach (bits[i]) begin
      sym.push_back(2'b00);
      if (bits[i]) begin
        z = 0;
        pol = ~pol;
        sym[i] = pol ? 2'b10 : 2'b01;
      end else if (++z == 8) begin
        z = 0;
        exp_sub++;
        sym[i-4] = pol ? 2'b10 : 2'b01;
        sym[i-3] = pol ? 2'b01 : 2'b10;
        sym[i-1] = pol ? 2'b01 : 2'b10;
        sym[i] = pol ? 2'b10 : 2'b01;
      end
    end
  endfunction
  task automatic conclude();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rst_n = 1'b0; global_clear = 1'b0; nrz_in = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0;
    reg_addr = '0; reg_wdata = '0; inj_en = 1'b0; inj_pos = 1'b0; inj_neg = 1'b0;
    void'($urandom(88596));
    bits = '{1'b1, 1'b1};
    for (int r = 0; r < 12; r++) begin
      repeat (10) bits.push_back(1'($urandom_range(0, 1)));
      repeat (run_tab[r % 4]) bits.push_back(1'b0);
      bits.push_back(1'b1);
    end
    build_exp();
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys);
    check({6'h00, tx_pos, tx_neg}, 8'h00);
    // Release on the fifth rising edge; idle zero keeps a stray mark out of the stream
    @(posedge clk_sys);
    rst_n <= 1'b1;
    n_sub = 0; n_viol = 0; n_rail = 0;
    // Loopback: rails checked 8 cycles after the pin, decoded data 18 cycles after
    for (int k = 0; k < bits.size() + 20; k++) begin
      @(posedge clk_sys);
      nrz_in <= (k < bits.size()) ? bits[k] : 1'b1;
      @(negedge clk_sys);
      if (k >= 8 && k - 8 < bits.size()) check({6'h00, tx_pos, tx_neg}, {6'h00, sym[k-8]});
      if (k >= 8 && k - 8 < bits.size()) check({6'h00, line_lvl}, {6'h00, sym[k-8][0], |sym[k-8]});
      if (k >= 18 && k - 18 < bits.size()) check({7'h00, nrz_out}, {7'h00, bits[k-18]});
    end
    check(8'(n_sub), 8'(exp_sub));
    check(8'(n_viol + n_rail), 8'h00);
    // Status and interrupt handling after the clean stream
    read_check(OFS_MASK, MASK_RST);
    read_check(OFS_STATUS, 8'h01);
    check({7'h00, irq}, 8'h00);
    reg_write(OFS_MASK, 8'h01);
    check({7'h00, irq}, 8'h01);
    reg_write(OFS_STATUS, 8'h01);
    check({7'h00, irq}, 8'h00);
    read_check(4'h2, 8'h00);
    // Master clear, then a forced violation and a both-rails symbol
    @(posedge clk_sys);
    global_clear <= 1'b1;
    repeat (3) @(posedge clk_sys);
    global_clear <= 1'b0;
    repeat (4) @(posedge clk_sys);
    // Line idle since the clear: three zeros seen, no mark sent yet
    read_check(OFS_LIVE, 8'h06);
    n_sub = 0; n_viol = 0; n_rail = 0;
    inj_en <= 1'b1;
    foreach (inj_tab[j]) begin
      @(posedge clk_sys);
      {inj_pos, inj_neg} <= inj_tab[j];
    end
    repeat (15) @(posedge clk_sys);
    @(negedge clk_sys);
    check(8'(n_viol), 8'h01);
    check(8'(n_rail), 8'h01);
    check(8'(n_sub), 8'h00);
    read_check(OFS_STATUS, 8'h06);
    check({7'h00, irq}, 8'h00);
    reg_write(OFS_MASK, 8'h06);
    check({7'h00, irq}, 8'h01);
    reg_write(OFS_STATUS, 8'h06);
    read_check(OFS_STATUS, 8'h00);
    check({7'h00, irq}, 8'h00);
    conclude();
  end
endmodule
`default_nettype wire
